// *** rtl/tmr_core.sv ***
// counting, compare, flag and waveform core of the 16-bit timer
`timescale 1ns/1ps
`include "tmr_defs.svh"

module tmr_core (
   input  wire logic           REF_CLK,
   input  wire logic           RST_B,
   input  wire logic           TICK,
   input  tmr_pkg::tmr_mode_t  MODE_SEL,
   input  tmr_pkg::tmr_act_t   ACTION_A,
   input  tmr_pkg::tmr_act_t   ACTION_B,
   input  wire logic           COUNT_WR,
   input  tmr_pkg::tmr_word_t  COUNT_WDATA,
   input  wire logic           CMP_A_WR,
   input  tmr_pkg::tmr_word_t  CMP_A_WDATA,
   input  wire logic           CMP_B_WR,
   input  tmr_pkg::tmr_word_t  CMP_B_WDATA,
   input  wire logic           CAP_TOP_WR,
   input  tmr_pkg::tmr_word_t  CAP_TOP_WDATA,
   input  wire logic           OVF_CLR,
   input  wire logic           CMP_A_CLR,
   input  wire logic           CMP_B_CLR,
   input  wire logic           CAP_CLR,
   input  wire logic           DIR_A,
   input  wire logic           DIR_B,
   output tmr_pkg::tmr_word_t  COUNT_VALUE,
   output tmr_pkg::tmr_word_t  COMPARE_A_VALUE,
   output tmr_pkg::tmr_word_t  COMPARE_B_VALUE,
   output tmr_pkg::tmr_word_t  CAPTURE_TOP_VALUE,
   output logic                OVERFLOW_FLAG,
   output logic                COMPARE_A_FLAG,
   output logic                COMPARE_B_FLAG,
   output logic                CAPTURE_FLAG,
   output logic                WAVEFORM_A_OUT,
   output logic                WAVEFORM_B_OUT,
   output logic                WAVEFORM_A_PIN,
   output logic                WAVEFORM_A_PIN_OE,
   output logic                WAVEFORM_B_PIN,
   output logic                WAVEFORM_B_PIN_OE
);
   import tmr_pkg::*;

   // ---------------------------------------------------------------
   // decoding helpers
   // ---------------------------------------------------------------
   function automatic tmr_kind_e mode_kind(input tmr_mode_t m);
      case (m)
         `TMR_MODE_NORMAL:   mode_kind = KIND_NORMAL;
         `TMR_MODE_CTC_A,
         `TMR_MODE_CTC_CAP:  mode_kind = KIND_CTC;
         `TMR_MODE_FAST8,
         `TMR_MODE_FAST9,
         `TMR_MODE_FAST10,
         `TMR_MODE_FAST_CAP,
         `TMR_MODE_FAST_A:   mode_kind = KIND_FAST;
         default:            mode_kind = KIND_OTHER;
      endcase
   endfunction

   // upper-bit mask for fixed-TOP modes, all ones otherwise
   function automatic tmr_word_t fixed_mask(input tmr_mode_t m);
      case (m)
         `TMR_MODE_FAST8:  fixed_mask = `TMR_TOP8;
         `TMR_MODE_FAST9:  fixed_mask = `TMR_TOP9;
         `TMR_MODE_FAST10: fixed_mask = `TMR_TOP10;
         default:          fixed_mask = `TMR_MAX;
      endcase
   endfunction

   function automatic logic top_is_cap(input tmr_mode_t m);
      top_is_cap = (m == `TMR_MODE_CTC_CAP) || (m == `TMR_MODE_FAST_CAP);
   endfunction

   // one step of a waveform state for one channel
   function automatic logic wave_step(input logic cur, input tmr_act_t act,
                                      input tmr_kind_e k, input logic hit,
                                      input logic wrap, input logic tog_ok);
      wave_step = cur;
      case (k)
         KIND_NORMAL, KIND_CTC: begin
            if (hit) begin
               case (act)
                  `TMR_ACT_TOGGLE: wave_step = ~cur;
                  `TMR_ACT_CLEAR:  wave_step = 1'b0;
                  `TMR_ACT_SET:    wave_step = 1'b1;
                  default:         wave_step = cur;
               endcase
            end
         end
         KIND_FAST: begin
            // wrap wins so a compare equal to TOP gives a steady level
            if (wrap && act == `TMR_ACT_CLEAR) begin
               wave_step = 1'b1;
            end else if (wrap && act == `TMR_ACT_SET) begin
               wave_step = 1'b0;
            end else if (hit) begin
               case (act)
                  `TMR_ACT_TOGGLE: wave_step = tog_ok ? ~cur : cur;
                  `TMR_ACT_CLEAR:  wave_step = 1'b0;
                  `TMR_ACT_SET:    wave_step = 1'b1;
                  default:         wave_step = cur;
               endcase
            end
         end
         default: wave_step = cur;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   tmr_word_t count_reg;
   tmr_word_t count_next;
   tmr_word_t cmp_a_buf_reg;
   tmr_word_t cmp_a_act_reg;
   tmr_word_t cmp_b_buf_reg;
   tmr_word_t cmp_b_act_reg;
   tmr_word_t cap_top_reg;
   logic      block_reg;
   logic      ovf_reg;
   logic      cmp_a_flag_reg;
   logic      cmp_b_flag_reg;
   logic      cap_flag_reg;
   logic      wave_a_reg;
   logic      wave_a_next;
   logic      wave_b_reg;
   logic      wave_b_next;
   logic      pin_a_reg;
   logic      pin_b_reg;
   logic      oe_a_reg;
   logic      oe_b_reg;

   tmr_kind_e kind;
   tmr_word_t top_val;
   tmr_word_t mask;
   logic      step;
   logic      live;
   logic      top_hit;
   logic      fast_wrap;
   logic      ovf_set;
   logic      match_a;
   logic      match_b;

   // ---------------------------------------------------------------
   // event decode
   // ---------------------------------------------------------------
   always_comb begin
      kind = mode_kind(MODE_SEL);
      mask = fixed_mask(MODE_SEL);
      case (MODE_SEL)
         `TMR_MODE_CTC_A,
         `TMR_MODE_FAST_A:   top_val = cmp_a_act_reg;
         `TMR_MODE_CTC_CAP,
         `TMR_MODE_FAST_CAP: top_val = cap_top_reg;
         `TMR_MODE_FAST8:    top_val = `TMR_TOP8;
         `TMR_MODE_FAST9:    top_val = `TMR_TOP9;
         `TMR_MODE_FAST10:   top_val = `TMR_TOP10;
         default:            top_val = `TMR_MAX;
      endcase
      step = TICK && !COUNT_WR && (kind != KIND_OTHER);
      live = step && !block_reg;
      top_hit = live && (count_reg == top_val) &&
                (kind == KIND_CTC || kind == KIND_FAST);
      fast_wrap = top_hit && (kind == KIND_FAST);
      if (kind == KIND_FAST) begin
         ovf_set = fast_wrap;
      end else begin
         ovf_set = step && (count_reg == `TMR_MAX);
      end
      match_a = live && (count_reg == cmp_a_act_reg);
      match_b = live && (count_reg == cmp_b_act_reg);
   end

   // ---------------------------------------------------------------
   // counter
   // ---------------------------------------------------------------
   // period is one plus TOP ticks, which sets the output rates
   always_comb begin
      if (COUNT_WR) begin
         count_next = COUNT_WDATA;
      end else if (!step) begin
         count_next = count_reg;
      end else if (top_hit) begin
         count_next = `TMR_BOTTOM;
      end else begin
         count_next = 16'(count_reg + 16'h0001);
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         count_reg <= `TMR_CNT_RST;
      end else begin
         count_reg <= count_next;
      end
   end

   // a write blocks matches until the next tick has gone by
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         block_reg <= 1'b0;
      end else if (COUNT_WR) begin
         block_reg <= 1'b1;
      end else if (TICK) begin
         block_reg <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // compare and top registers
   // ---------------------------------------------------------------
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         cmp_a_buf_reg <= `TMR_CMP_RST;
         cmp_a_act_reg <= `TMR_CMP_RST;
      end else begin
         if (CMP_A_WR) begin
            cmp_a_buf_reg <= CMP_A_WDATA & mask;
         end
         if (CMP_A_WR && kind != KIND_FAST) begin
            cmp_a_act_reg <= CMP_A_WDATA & mask;
         end else if (fast_wrap) begin
            cmp_a_act_reg <= cmp_a_buf_reg;
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         cmp_b_buf_reg <= `TMR_CMP_RST;
         cmp_b_act_reg <= `TMR_CMP_RST;
      end else begin
         if (CMP_B_WR) begin
            cmp_b_buf_reg <= CMP_B_WDATA & mask;
         end
         if (CMP_B_WR && kind != KIND_FAST) begin
            cmp_b_act_reg <= CMP_B_WDATA & mask;
         end else if (fast_wrap) begin
            cmp_b_act_reg <= cmp_b_buf_reg;
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         cap_top_reg <= `TMR_CMP_RST;
      end else if (CAP_TOP_WR) begin
         cap_top_reg <= CAP_TOP_WDATA;
      end
   end

   // ---------------------------------------------------------------
   // flags: a set in the clearing cycle wins
   // ---------------------------------------------------------------
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         ovf_reg        <= 1'b0;
         cmp_a_flag_reg <= 1'b0;
         cmp_b_flag_reg <= 1'b0;
         cap_flag_reg   <= 1'b0;
      end else begin
         ovf_reg        <= ovf_set | (ovf_reg & ~OVF_CLR);
         cmp_a_flag_reg <= match_a | (cmp_a_flag_reg & ~CMP_A_CLR);
         cmp_b_flag_reg <= match_b | (cmp_b_flag_reg & ~CMP_B_CLR);
         cap_flag_reg   <= (top_hit & top_is_cap(MODE_SEL)) |
                           (cap_flag_reg & ~CAP_CLR);
      end
   end

   // ---------------------------------------------------------------
   // waveform state and pins
   // ---------------------------------------------------------------
   always_comb begin
      wave_a_next = wave_step(wave_a_reg, ACTION_A, kind, match_a, fast_wrap,
                              MODE_SEL == `TMR_MODE_FAST_A);
      wave_b_next = wave_step(wave_b_reg, ACTION_B, kind, match_b, fast_wrap,
                              1'b0);
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         wave_a_reg <= `TMR_WAVE_RST;
         wave_b_reg <= `TMR_WAVE_RST;
      end else begin
         wave_a_reg <= wave_a_next;
         wave_b_reg <= wave_b_next;
      end
   end

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         pin_a_reg <= `TMR_WAVE_RST;
         pin_b_reg <= `TMR_WAVE_RST;
         oe_a_reg  <= 1'b0;
         oe_b_reg  <= 1'b0;
      end else begin
         pin_a_reg <= wave_a_next;
         pin_b_reg <= wave_b_next;
         oe_a_reg  <= DIR_A;
         oe_b_reg  <= DIR_B;
      end
   end

   assign COUNT_VALUE       = count_reg;
   assign COMPARE_A_VALUE   = cmp_a_act_reg;
   assign COMPARE_B_VALUE   = cmp_b_act_reg;
   assign CAPTURE_TOP_VALUE = cap_top_reg;
   assign OVERFLOW_FLAG     = ovf_reg;
   assign COMPARE_A_FLAG    = cmp_a_flag_reg;
   assign COMPARE_B_FLAG    = cmp_b_flag_reg;
   assign CAPTURE_FLAG      = cap_flag_reg;
   assign WAVEFORM_A_OUT    = wave_a_reg;
   assign WAVEFORM_B_OUT    = wave_b_reg;
   assign WAVEFORM_A_PIN    = pin_a_reg;
   assign WAVEFORM_A_PIN_OE = oe_a_reg;
   assign WAVEFORM_B_PIN    = pin_b_reg;
   assign WAVEFORM_B_PIN_OE = oe_b_reg;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_B);

   sequence s_write_then_tick;
      COUNT_WR ##1 TICK;
   endsequence

   chk_normal_wrap: assert property (
      (MODE_SEL == `TMR_MODE_NORMAL && TICK && !COUNT_WR && count_reg == `TMR_MAX)
      |=> (COUNT_VALUE == `TMR_BOTTOM) && OVERFLOW_FLAG)
      else $error("normal mode did not wrap to zero with overflow");
   chk_ovf_clear_set: assert property (
      (OVF_CLR && !ovf_set) |=> !OVERFLOW_FLAG)
      else $error("overflow flag not cleared by service");
   chk_count_write: assert property (
      COUNT_WR |=> COUNT_VALUE == $past(COUNT_WDATA))
      else $error("count write not taken");
   chk_top_clear: assert property (
      top_hit |=> (COUNT_VALUE == `TMR_BOTTOM) && (ovf_reg || kind != KIND_FAST))
      else $error("counter not cleared at top");
   chk_ctc_toggle: assert property (
      (kind == KIND_CTC && ACTION_A == `TMR_ACT_TOGGLE && match_a)
      |=> WAVEFORM_A_OUT != $past(wave_a_reg))
      else $error("channel a did not toggle on match");
   chk_pwm_buffer: assert property (
      fast_wrap |=> COMPARE_A_VALUE == $past(cmp_a_buf_reg))
      else $error("compare buffer not loaded at top");
   chk_block_match: assert property (
      s_write_then_tick |-> !match_a && !match_b && !top_hit)
      else $error("match not blocked after count write");
   chk_fast_wrap_set: assert property (
      (fast_wrap && ACTION_A == `TMR_ACT_CLEAR) |=> WAVEFORM_A_OUT && WAVEFORM_A_PIN)
      else $error("fast pwm output not set at wrap");
   chk_fixed_mask: assert property (
      (CMP_A_WR && MODE_SEL == `TMR_MODE_FAST8) |=> (cmp_a_buf_reg & ~`TMR_TOP8) == `TMR_BOTTOM)
      else $error("upper compare bits not masked");
   chk_pin_dir: assert property (
      ##1 (WAVEFORM_A_PIN_OE == $past(DIR_A)) && (WAVEFORM_A_PIN == WAVEFORM_A_OUT))
      else $error("pin drive does not follow direction");
   chk_tick_gate: assert property (
      (!TICK && !COUNT_WR) |=> $stable(COUNT_VALUE) && !$rose(OVERFLOW_FLAG))
      else $error("counter moved without a tick");
   chk_reserved_hold: assert property (
      (MODE_SEL == `TMR_MODE_RSVD && !COUNT_WR) |=> $stable(COUNT_VALUE) && $stable(WAVEFORM_A_OUT))
      else $error("reserved mode changed state");

endmodule

// *** rtl/tmr_defs.svh ***
// constants for the 16-bit timer counting and waveform core
`ifndef TMR_DEFS_SVH
`define TMR_DEFS_SVH

`define TMR_MODE_NORMAL   4'h0
`define TMR_MODE_CTC_A    4'h4
`define TMR_MODE_FAST8    4'h5
`define TMR_MODE_FAST9    4'h6
`define TMR_MODE_FAST10   4'h7
`define TMR_MODE_CTC_CAP  4'hC
`define TMR_MODE_RSVD     4'hD
`define TMR_MODE_FAST_CAP 4'hE
`define TMR_MODE_FAST_A   4'hF

`define TMR_BOTTOM        16'h0000
`define TMR_MAX           16'hFFFF
`define TMR_TOP8          16'h00FF
`define TMR_TOP9          16'h01FF
`define TMR_TOP10         16'h03FF

`define TMR_ACT_NONE      2'h0
`define TMR_ACT_TOGGLE    2'h1
`define TMR_ACT_CLEAR     2'h2
`define TMR_ACT_SET       2'h3

`define TMR_CNT_RST       16'h0000
`define TMR_CMP_RST       16'h0000
`define TMR_WAVE_RST      1'b0

`endif

// *** rtl/tmr_pkg.sv ***
// types shared by the timer core
package tmr_pkg;
   typedef logic [15:0] tmr_word_t;
   typedef logic [3:0]  tmr_mode_t;
   typedef logic [1:0]  tmr_act_t;
   typedef enum logic [1:0] {
      KIND_NORMAL,
      KIND_CTC,
      KIND_FAST,
      KIND_OTHER
   } tmr_kind_e;
endpackage

// *** verification/tmr_core_tb.sv ***
// self-checking testbench for the timer counting and waveform core
`timescale 1ns/1ps
`include "tmr_defs.svh"

module tmr_core_tb;
   import tmr_pkg::*;

   // ----------------------------------------------------------------
   // stimulus and wiring
   // ----------------------------------------------------------------
   logic        ref_clk  = 1'b0;
   logic        rst_b    = 1'b0;
   logic        tick     = 1'b0;
   tmr_mode_t   mode_sel = `TMR_MODE_NORMAL;
   tmr_act_t    action_a = `TMR_ACT_NONE;
   tmr_act_t    action_b = `TMR_ACT_NONE;
   logic [3:0]  wr_s     = 4'h0;
   logic [3:0]  clr_s    = 4'h0;
   tmr_word_t   wd       = 16'h0000;
   logic        dir_a    = 1'b0;
   logic        dir_b    = 1'b0;
   tmr_word_t   count_value;
   tmr_word_t   cmp_a_value;
   tmr_word_t   cmp_b_value;
   tmr_word_t   cap_value;
   logic        ovf_flag;
   logic        cmp_a_flag;
   logic        cmp_b_flag;
   logic        cap_flag;
   logic        wave_a;
   logic        wave_b;
   logic        pin_a;
   logic        pin_a_oe;
   logic        pin_b;
   logic        pin_b_oe;
   int          fails    = 0;
   int          n_checks = 0;
   tmr_mode_t   fast_mode [3] = '{`TMR_MODE_FAST8, `TMR_MODE_FAST9, `TMR_MODE_FAST10};
   tmr_word_t   fast_top  [3] = '{`TMR_TOP8, `TMR_TOP9, `TMR_TOP10};

   always #20 ref_clk = ~ref_clk;

   tmr_core tmr_core_i (
      .REF_CLK           (ref_clk),
      .RST_B             (rst_b),
      .TICK              (tick),
      .MODE_SEL          (mode_sel),
      .ACTION_A          (action_a),
      .ACTION_B          (action_b),
      .COUNT_WR          (wr_s[0]),
      .COUNT_WDATA       (wd),
      .CMP_A_WR          (wr_s[1]),
      .CMP_A_WDATA       (wd),
      .CMP_B_WR          (wr_s[2]),
      .CMP_B_WDATA       (wd),
      .CAP_TOP_WR        (wr_s[3]),
      .CAP_TOP_WDATA     (wd),
      .OVF_CLR           (clr_s[0]),
      .CMP_A_CLR         (clr_s[1]),
      .CMP_B_CLR         (clr_s[2]),
      .CAP_CLR           (clr_s[3]),
      .DIR_A             (dir_a),
      .DIR_B             (dir_b),
      .COUNT_VALUE       (count_value),
      .COMPARE_A_VALUE   (cmp_a_value),
      .COMPARE_B_VALUE   (cmp_b_value),
      .CAPTURE_TOP_VALUE (cap_value),
      .OVERFLOW_FLAG     (ovf_flag),
      .COMPARE_A_FLAG    (cmp_a_flag),
      .COMPARE_B_FLAG    (cmp_b_flag),
      .CAPTURE_FLAG      (cap_flag),
      .WAVEFORM_A_OUT    (wave_a),
      .WAVEFORM_B_OUT    (wave_b),
      .WAVEFORM_A_PIN    (pin_a),
      .WAVEFORM_A_PIN_OE (pin_a_oe),
      .WAVEFORM_B_PIN    (pin_b),
      .WAVEFORM_B_PIN_OE (pin_b_oe)
   );

   // ----------------------------------------------------------------
   // access tasks and compares
   // ----------------------------------------------------------------
   // idx 0 count, 1 compare a, 2 compare b, 3 capture/top
   task automatic wr(input int idx, input tmr_word_t d);
      @(posedge ref_clk);
      wr_s[idx] <= 1'b1;
      wd        <= d;
      @(posedge ref_clk);
      wr_s      <= 4'h0;
      #1;
   endtask

   // mask bits: 0 overflow, 1 compare a, 2 compare b, 3 capture
   task automatic clr(input logic [3:0] m);
      @(posedge ref_clk);
      clr_s <= m;
      @(posedge ref_clk);
      clr_s <= 4'h0;
      #1;
   endtask

   // n consecutive timer ticks
   task automatic run(input int n);
      @(posedge ref_clk);
      tick <= 1'b1;
      repeat (n) @(posedge ref_clk);
      tick <= 1'b0;
      #1;
   endtask

   task automatic setm(input tmr_mode_t m, input tmr_act_t a, input tmr_act_t b);
      @(posedge ref_clk);
      mode_sel <= m;
      action_a <= a;
      action_b <= b;
   endtask

   task automatic check_w(input tmr_word_t got, input tmr_word_t exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t word got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_b(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t bit got %b expected %b", $time, got, exp);
      end
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial begin
      repeat (12) @(posedge ref_clk);
      rst_b <= 1'b1;
      #1;
      check_w(count_value, 16'h0000);
      check_b(wave_a, 1'b0);
      check_b(pin_a_oe, 1'b0);
      $display("reset test done");

      wr(0, 16'hFFFE);
      run(1);
      check_w(count_value, 16'hFFFF);
      check_b(ovf_flag, 1'b0);
      run(1);
      check_w(count_value, 16'h0000);
      check_b(ovf_flag, 1'b1);
      run(1);
      check_b(ovf_flag, 1'b1);
      check_b(wave_a, 1'b0);
      clr(4'h1);
      check_b(ovf_flag, 1'b0);
      wr(2, 16'h0005);
      wr(0, 16'h0005);
      clr(4'hF);
      run(1);
      check_w(count_value, 16'h0006);
      check_b(cmp_b_flag, 1'b0);
      wr(0, 16'h0004);
      run(2);
      check_b(cmp_b_flag, 1'b1);
      wr(0, 16'h0009);
      repeat (5) @(posedge ref_clk);
      #1;
      check_w(count_value, 16'h0009);
      $display("normal mode test done");

      setm(`TMR_MODE_CTC_A, `TMR_ACT_TOGGLE, `TMR_ACT_NONE);
      wr(1, 16'h0002);
      check_w(cmp_a_value, 16'h0002);
      wr(0, 16'h0000);
      clr(4'hF);
      run(3);
      check_w(count_value, 16'h0000);
      check_b(cmp_a_flag, 1'b1);
      check_b(wave_a, 1'b1);
      run(3);
      check_b(wave_a, 1'b0);
      wr(0, 16'h0008);
      run(1);
      check_w(count_value, 16'h0009);
      wr(0, 16'hFFFE);
      clr(4'h1);
      run(3);
      check_w(count_value, 16'h0001);
      check_b(ovf_flag, 1'b1);
      setm(`TMR_MODE_CTC_CAP, `TMR_ACT_NONE, `TMR_ACT_NONE);
      wr(3, 16'h0003);
      wr(0, 16'h0000);
      clr(4'hF);
      run(4);
      check_w(count_value, 16'h0000);
      check_b(cap_flag, 1'b1);
      $display("clear on match test done");

      setm(`TMR_MODE_FAST8, `TMR_ACT_NONE, `TMR_ACT_NONE);
      wr(1, 16'h1280);
      check_w(cmp_a_value, 16'h0002);
      for (int i = 0; i < 3; i++) begin
         setm(fast_mode[i], `TMR_ACT_NONE, `TMR_ACT_NONE);
         wr(2, 16'hFFFF);
         wr(0, fast_top[i] - 16'h0001);
         clr(4'h1);
         run(1);
         check_w(count_value, fast_top[i]);
         check_b(ovf_flag, 1'b0);
         run(1);
         check_w(count_value, 16'h0000);
         check_b(ovf_flag, 1'b1);
         check_w(cmp_b_value, fast_top[i]);
         check_w(cmp_a_value, 16'h0080);
      end
      $display("fixed top test done");

      setm(`TMR_MODE_FAST_CAP, `TMR_ACT_CLEAR, `TMR_ACT_SET);
      wr(3, 16'h0004);
      check_w(cap_value, 16'h0004);
      wr(1, 16'h0001);
      wr(2, 16'h0002);
      wr(0, 16'h0003);
      clr(4'hF);
      run(2);
      check_w(count_value, 16'h0000);
      check_w(cmp_a_value, 16'h0001);
      check_b(ovf_flag, 1'b1);
      check_b(cap_flag, 1'b1);
      check_b(wave_a, 1'b1);
      run(2);
      check_b(wave_a, 1'b0);
      run(1);
      check_b(wave_b, 1'b1);
      check_b(cmp_b_flag, 1'b1);
      run(2);
      check_w(count_value, 16'h0000);
      check_b(wave_a, 1'b1);
      check_b(wave_b, 1'b0);
      @(posedge ref_clk);
      dir_a <= 1'b1;
      repeat (2) @(posedge ref_clk);
      #1;
      check_b(pin_a_oe, 1'b1);
      check_b(pin_a, 1'b1);
      check_b(pin_b_oe, 1'b0);
      check_b(pin_b, 1'b0);
      wr(0, 16'h0004);
      wr(3, 16'h0003);
      run(2);
      check_w(count_value, 16'h0006);
      $display("fast pwm test done");

      setm(`TMR_MODE_RSVD, `TMR_ACT_TOGGLE, `TMR_ACT_TOGGLE);
      run(3);
      check_w(count_value, 16'h0006);
      check_b(wave_a, 1'b1);
      check_b(wave_b, 1'b0);
      $display("reserved mode test done");

      setm(`TMR_MODE_FAST_A, `TMR_ACT_TOGGLE, `TMR_ACT_NONE);
      wr(1, 16'h0003);
      wr(0, 16'h0000);
      clr(4'hF);
      run(2);
      check_w(count_value, 16'h0000);
      check_w(cmp_a_value, 16'h0003);
      check_b(ovf_flag, 1'b1);
      check_b(cmp_a_flag, 1'b1);
      check_b(wave_a, 1'b0);
      run(4);
      check_w(count_value, 16'h0000);
      check_b(wave_a, 1'b1);
      check_b(wave_b, 1'b0);
      $display("fast pwm compare top test done");
      end_sim();
   end

   initial begin
      repeat (20000) @(posedge ref_clk);
      fails++;
      end_sim();
   end
endmodule
